// >>> design/seq_io_consts.svh
// Offsets, field positions, reset values and timing of the sequence I/O block
// Assumes a 100 MHz hclk and word-aligned AHB-Lite register accesses
`ifndef SEQ_IO_CONSTS_SVH
`define SEQ_IO_CONSTS_SVH
// ============================================================
// Register byte offsets
`define OFF_DRIVE_CTRL 8'h00
`define OFF_SEQ_STATUS 8'h04
`define OFF_IRQ_STATUS 8'h08
`define OFF_IRQ_CLEAR 8'h0c
`define OFF_IRQ_ENABLE 8'h10
`define OFF_SEQ_CMD 8'h14
// ============================================================
// Drive control fields
`define CTRL_ERROR 0
`define CTRL_WARN 1
`define CTRL_BRAKE 2
`define CTRL_CPWR 3
`define CTRL_MPWR 4
`define CTRL_CODE 5
`define CTRL_DONE 8
`define CTRL_USER 9
`define CTRL_MASK 32'h0000_3fff
`define CTRL_RESET 32'h0000_0000
// ============================================================
// Command and interrupt fields
`define CMD_TABLE_DONE 0
`define CMD_HOME_DONE 1
`define IRQ_BITS 6
`define IRQ_EN_RESET 6'h00
// ============================================================
// Timing
`define CLK_PERIOD_NS 10
`define FAULT_PULSE_MS 2000
`define FAULT_PULSE_CYCLES (64'd`FAULT_PULSE_MS * 64'd1000000 / 64'd`CLK_PERIOD_NS)
`endif

// >>> design/seq_io_pkg.sv
// Types shared by the sequence I/O block and its surroundings
// Assumes all sequence pins except servo_fault_out_n are active low
package seq_io_pkg;
    // ============================================================
    // Pin groups
    typedef struct packed {
        logic mode_sel_n;
        logic run_n;
        logic clear_fwd_n;
        logic [6:0] table_pick_n;
    } seq_in_type;

    typedef struct packed {
        logic servo_fault_out_n;
        logic fault_caution_n;
        logic brake_release_out_n;
        logic drive_ready_n;
        logic [2:0] fault_code_n;
        logic target_reached_out_n;
        logic [4:0] user_flag_out_n;
    } seq_out_type;

    // ============================================================
    // Sequencer states
    typedef enum logic [1:0] {
        TBL_IDLE = 2'b00,
        TBL_RUN = 2'b01,
        TBL_HALT = 2'b11
    } table_state_type;

    typedef enum logic [1:0] {
        HOME_IDLE = 2'b00,
        HOME_SEEK = 2'b01,
        HOME_PAUSE = 2'b11
    } home_state_type;
endpackage

// >>> design/indexer_sequence_io.sv
// Sequence I/O logic of an indexer drive, with an AHB-Lite register slave
// Assumes the drive firmware reports faults, power and motion over the bus
`timescale 1ns/1ns
`include "seq_io_consts.svh"

module indexer_sequence_io #(
    parameter logic [31:0] PULSE_CYCLES = 32'(`FAULT_PULSE_CYCLES)
) (
    input logic hclk,
    input logic hresetn,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic hready,
    input logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input seq_io_pkg::seq_in_type seq_in,
    output seq_io_pkg::seq_out_type seq_out,
    output logic irq
);
    import seq_io_pkg::*;

    // ============================================================
    // Declarations
    seq_in_type sync1;
    seq_in_type sync2;
    seq_in_type prev;
    table_state_type tbl_state;
    home_state_type home_state;
    logic [6:0] tbl_index;
    logic [3:0] speed_pick;
    logic jog_fwd;
    logic jog_rev;
    logic [31:0] drive_ctrl;
    logic [31:0] pulse_cnt;
    logic err_prev;
    logic [`IRQ_BITS-1:0] irq_stat;
    logic [`IRQ_BITS-1:0] irq_en;
    logic [`IRQ_BITS-1:0] irq_events;
    logic [`IRQ_BITS-1:0] irq_clr;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic take;
    logic mode0;
    logic run_on;
    logic run_rise;
    logic run_fall;
    logic clr_on;
    logic rev_on;
    logic tbl_done;
    logic home_done;
    logic caution;

    function automatic logic on(input logic pin_n);
        return ~pin_n;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ============================================================
    // Pin synchroniser; sync1 feeds sync2 only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1 <= '1;
            sync2 <= '1;
            prev <= '1;
        end else begin
            sync1 <= seq_in;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    sync_delay_a: assert property (sync2 == $past(seq_in, 2))
        else $error("pin synchroniser delay wrong");

    // ============================================================
    // Decode of the shared pins
    always_comb begin
        mode0 = on(sync2.mode_sel_n);
        run_on = on(sync2.run_n);
        run_rise = run_on & ~on(prev.run_n);
        run_fall = ~run_on & on(prev.run_n);
        clr_on = on(sync2.clear_fwd_n);
        rev_on = on(sync2.table_pick_n[0]);
    end

    assign tbl_done = wr_pend & hit(wr_addr, `OFF_SEQ_CMD) & hwdata[`CMD_TABLE_DONE];
    assign home_done = wr_pend & hit(wr_addr, `OFF_SEQ_CMD) & hwdata[`CMD_HOME_DONE];

    // ============================================================
    // Program table sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tbl_state <= TBL_IDLE;
            tbl_index <= 7'h00;
        end else begin
            unique case (tbl_state)
                TBL_IDLE: begin
                    if (mode0 && run_rise) begin
                        tbl_state <= TBL_RUN;
                        tbl_index <= ~sync2.table_pick_n;
                    end
                end
                TBL_RUN: begin
                    if (mode0 && run_fall) begin
                        tbl_state <= TBL_HALT;
                    end else if (tbl_done) begin
                        tbl_state <= TBL_IDLE;
                    end
                end
                TBL_HALT: begin
                    if (mode0 && run_rise) begin
                        tbl_state <= TBL_RUN;
                    end else if (mode0 && clr_on) begin
                        tbl_state <= TBL_IDLE;
                    end
                end
                default: begin
                    tbl_state <= TBL_IDLE;
                end
            endcase
        end
    end

    table_start_a: assert property (
        tbl_state == TBL_IDLE && mode0 && run_rise
        |=> tbl_state == TBL_RUN && tbl_index == ~$past(sync2.table_pick_n))
        else $error("table start or index capture wrong");

    table_halt_a: assert property (
        tbl_state == TBL_RUN && mode0 && run_fall |=> tbl_state == TBL_HALT)
        else $error("table did not halt");

    table_resume_a: assert property (
        tbl_state == TBL_HALT && mode0 && run_rise
        |=> tbl_state == TBL_RUN && $stable(tbl_index))
        else $error("table did not resume");

    table_clear_a: assert property (
        tbl_state == TBL_HALT && mode0 && clr_on && !run_rise |=> tbl_state == TBL_IDLE)
        else $error("table clear ignored");

    table_mode_a: assert property (
        tbl_state == TBL_IDLE && !mode0 |=> tbl_state == TBL_IDLE)
        else $error("table ran outside set 0");

    // ============================================================
    // Origin search sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            home_state <= HOME_IDLE;
        end else begin
            unique case (home_state)
                HOME_IDLE, HOME_PAUSE: begin
                    if (!mode0 && run_rise) begin
                        home_state <= HOME_SEEK;
                    end
                end
                HOME_SEEK: begin
                    if (!mode0 && run_fall) begin
                        home_state <= HOME_PAUSE;
                    end else if (home_done) begin
                        home_state <= HOME_IDLE;
                    end
                end
                default: begin
                    home_state <= HOME_IDLE;
                end
            endcase
        end
    end

    home_seek_a: assert property (
        !mode0 && home_state != HOME_SEEK && run_rise |=> home_state == HOME_SEEK)
        else $error("origin search did not start");

    home_pause_a: assert property (
        !mode0 && home_state == HOME_SEEK && run_fall |=> home_state == HOME_PAUSE)
        else $error("origin search not interrupted");

    // ============================================================
    // Manual motion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            jog_fwd <= 1'b0;
            jog_rev <= 1'b0;
            speed_pick <= 4'h0;
        end else begin
            jog_fwd <= ~mode0 & clr_on;
            jog_rev <= ~mode0 & rev_on;
            if (!mode0) begin
                speed_pick <= ~sync2.table_pick_n[4:1];
            end
        end
    end

    jog_fwd_a: assert property (jog_fwd == $past(!mode0 && clr_on))
        else $error("forward motion mismatch");

    jog_rev_a: assert property (jog_rev == $past(!mode0 && rev_on))
        else $error("reverse motion mismatch");

    // ============================================================
    // Fault/caution pulse; counter reloads on every new error
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_prev <= 1'b0;
            pulse_cnt <= 32'h0;
        end else begin
            err_prev <= drive_ctrl[`CTRL_ERROR];
            if (drive_ctrl[`CTRL_ERROR] && !err_prev) begin
                pulse_cnt <= PULSE_CYCLES;
            end else if (pulse_cnt != 32'h0) begin
                pulse_cnt <= pulse_cnt - 32'h1;
            end
        end
    end

    assign caution = (pulse_cnt != 32'h0) | drive_ctrl[`CTRL_WARN];

    pulse_load_a: assert property (
        $rose(drive_ctrl[`CTRL_ERROR]) |=> pulse_cnt == PULSE_CYCLES ##1 !seq_out.fault_caution_n)
        else $error("fault pulse not started");

    // ============================================================
    // Output pins, all registered; active low except servo_fault_out_n, which goes high on an error
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_out <= '1;
        end else begin
            seq_out.servo_fault_out_n <= drive_ctrl[`CTRL_ERROR];
            seq_out.fault_caution_n <= ~caution;
            seq_out.brake_release_out_n <= ~drive_ctrl[`CTRL_BRAKE];
            seq_out.drive_ready_n <= ~(drive_ctrl[`CTRL_CPWR] & drive_ctrl[`CTRL_MPWR]
                & ~drive_ctrl[`CTRL_ERROR]);
            seq_out.fault_code_n <= ~drive_ctrl[`CTRL_CODE+:3];
            seq_out.target_reached_out_n <= ~drive_ctrl[`CTRL_DONE];
            seq_out.user_flag_out_n <= ~drive_ctrl[`CTRL_USER+:5];
        end
    end

    fault_out_a: assert property (
        $rose(drive_ctrl[`CTRL_ERROR]) |=> seq_out.servo_fault_out_n && seq_out.drive_ready_n)
        else $error("servo fault output not released");

    warn_hold_a: assert property (drive_ctrl[`CTRL_WARN][*2] |-> !seq_out.fault_caution_n)
        else $error("warning not held on output");

    ready_out_a: assert property (
        !seq_out.drive_ready_n |-> $past(drive_ctrl[`CTRL_CPWR] && drive_ctrl[`CTRL_MPWR]
        && !drive_ctrl[`CTRL_ERROR]))
        else $error("ready without power or with fault");

    brake_out_a: assert property (
        $fell(drive_ctrl[`CTRL_BRAKE]) |=> seq_out.brake_release_out_n)
        else $error("brake output late");

    code_out_a: assert property (
        $changed(drive_ctrl[`CTRL_CODE+:3]) |=> seq_out.fault_code_n == ~$past(drive_ctrl[7:5]))
        else $error("fault code mismatch");

    // ============================================================
    // Interrupts; a new event wins over a clear in the same cycle
    assign irq_events = {
        mode0 != on(prev.mode_sel_n),
        home_state == HOME_SEEK && !mode0 && run_fall,
        home_state != HOME_SEEK && !mode0 && run_rise,
        tbl_state == TBL_HALT && mode0 && clr_on && !run_rise,
        tbl_state == TBL_RUN && mode0 && run_fall,
        tbl_state != TBL_RUN && mode0 && run_rise
    };

    assign irq_clr = (wr_pend && hit(wr_addr, `OFF_IRQ_CLEAR)) ?
        hwdata[`IRQ_BITS-1:0] : '0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= '0;
            irq_en <= `IRQ_EN_RESET;
            irq <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_events;
            if (wr_pend && hit(wr_addr, `OFF_IRQ_ENABLE)) begin
                irq_en <= hwdata[`IRQ_BITS-1:0];
            end
            irq <= |(irq_stat & irq_en);
        end
    end

    irq_level_a: assert property (irq == $past(|(irq_stat & irq_en)))
        else $error("interrupt output mismatch");

    irq_set_a: assert property (
        irq_events != '0 |=> (irq_stat & $past(irq_events)) == $past(irq_events))
        else $error("interrupt event lost");

    // ============================================================
    // AHB-Lite slave; zero wait states, always OKAY
    // A read right after a write to the same word returns the old value
    assign take = hsel & hready & htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend <= take & hwrite;
            wr_addr <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0;
            if (take && !hwrite) begin
                unique case (haddr[7:0])
                    `OFF_DRIVE_CTRL: hrdata <= drive_ctrl;
                    `OFF_SEQ_STATUS: hrdata <= {13'h0, caution, speed_pick, tbl_index,
                        jog_rev, jog_fwd, home_state, tbl_state, ~mode0};
                    `OFF_IRQ_STATUS: hrdata <= {26'h0, irq_stat};
                    `OFF_IRQ_ENABLE: hrdata <= {26'h0, irq_en};
                    default: hrdata <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_ctrl <= `CTRL_RESET;
        end else if (wr_pend && hit(wr_addr, `OFF_DRIVE_CTRL)) begin
            drive_ctrl <= hwdata & `CTRL_MASK;
        end
    end

    bus_ready_a: assert property (hreadyout && !hresp)
        else $error("slave must answer OKAY with no wait");

    read_idle_a: assert property (!(take && !hwrite) |=> hrdata == 32'h0)
        else $error("read data outside its data phase");

endmodule // indexer_sequence_io

// >>> testbench/seq_host_model.sv
// Host controller model driving the active-low sequence pins
// Assumes the bench gives it active-high commands right after a rising edge
`timescale 1ns/1ns

module seq_host_model
    import seq_io_pkg::*;
(
    input logic hclk,
    input logic hresetn,
    input logic mode0,
    input logic run,
    input logic clr_fwd,
    input logic [6:0] pick,
    output seq_io_pkg::seq_in_type seq_in
);
    // ============================================================
    // Pin drivers
    // Pins idle high while in reset, so no edge is seen on release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_in <= '1;
        end else begin
            seq_in.mode_sel_n <= ~mode0;
            seq_in.run_n <= ~run;
            seq_in.clear_fwd_n <= ~clr_fwd;
            seq_in.table_pick_n <= ~pick;
        end
    end
endmodule // seq_host_model

// >>> testbench/indexer_sequence_io_tb.sv
// Self-checking bench for the sequence I/O block
// Assumes the host model on the pins and an AHB-Lite master task here
`timescale 1ns/1ns
`include "seq_io_consts.svh"

module indexer_sequence_io_tb;
    import seq_io_pkg::*;
    localparam logic [31:0] PULSE = 32'd20;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd, ctl;
    logic [1:0] htrans;
    logic m_mode0, m_run, m_clr;
    logic [6:0] m_pick, idx;
    logic [15:0] seed;
    seq_in_type seq_in;
    seq_out_type seq_out;
    int n_fail, checks, cnt;

    indexer_sequence_io #(.PULSE_CYCLES(PULSE)) dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .seq_in(seq_in), .seq_out(seq_out), .irq(irq));
    seq_host_model host (.hclk(hclk), .hresetn(hresetn), .mode0(m_mode0), .run(m_run),
        .clr_fwd(m_clr), .pick(m_pick), .seq_in(seq_in));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ============================================================
    // Helpers
    task stop_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    function logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function seq_out_type exp_out(input logic [31:0] c);
        exp_out.servo_fault_out_n = c[0];
        exp_out.fault_caution_n = ~c[1];
        exp_out.brake_release_out_n = ~c[2];
        exp_out.drive_ready_n = ~(c[3] & c[4] & ~c[0]);
        exp_out.fault_code_n = ~c[7:5];
        exp_out.target_reached_out_n = ~c[8];
        exp_out.user_flag_out_n = ~c[13:9];
    endfunction

    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            n_fail++;
            $display("wrong value at %0t: bus never ready", $time);
            stop_test();
        end
    endtask

    // Single word transfer; read data taken at the data phase edge
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        wait_rdy();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    // Pin effects land a few edges late, so poll under a bound
    task poll(input logic [7:0] a, input logic [31:0] mask, exp, input string msg);
        int n;
        n = 0;
        do begin
            bus(1'b0, a, 32'h0);
            n++;
        end while ((rd & mask) !== exp && n < 20);
        chk(rd & mask, exp, msg);
        if ((rd & mask) !== exp) stop_test();
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        n_fail++;
        $display("wrong value at %0t: run timed out", $time);
        stop_test();
    end

    // ============================================================
    // Main sequence
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0; hwdata = '0;
        m_mode0 = 1'b0; m_run = 1'b0; m_clr = 1'b0; m_pick = '0; seed = 16'h002c;
        n_fail = 0; checks = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, `OFF_DRIVE_CTRL, 32'h0);
        chk(rd, 32'h0, "control reset");
        chk({hreadyout, hresp, irq}, 3'b100, "bus reset");
        chk(seq_out, exp_out(32'h0), "outputs after reset");
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            ctl = (i == 0) ? 32'hffff_fffe : {18'h0, seed[13:1], 1'b0};
            bus(1'b1, `OFF_DRIVE_CTRL, ctl);
            repeat (2) @(negedge hclk);
            chk(seq_out, exp_out(ctl), "outputs follow control");
            @(posedge hclk);
            bus(1'b0, `OFF_DRIVE_CTRL, 32'h0);
            chk(rd, ctl & 32'h3fff, "control readback");
        end
        // Error pulse length, powers on so only the error drops ready
        bus(1'b1, `OFF_DRIVE_CTRL, 32'h18);
        bus(1'b1, `OFF_DRIVE_CTRL, 32'h19);
        cnt = 0;
        for (int i = 0; i < 3 * PULSE; i++) begin
            @(negedge hclk);
            if (seq_out.fault_caution_n === 1'b0) cnt++;
        end
        chk(cnt, PULSE, "caution pulse length");
        chk({seq_out.servo_fault_out_n, seq_out.drive_ready_n}, 2'b11, "fault");
        @(posedge hclk);
        bus(1'b1, `OFF_DRIVE_CTRL, 32'h18);
        bus(1'b1, `OFF_IRQ_ENABLE, 32'h3f);
        bus(1'b1, `OFF_IRQ_CLEAR, 32'h3f);
        // Table set: start, halt, resume with changed pick pins and the index kept, clear
        seed = lfsr(seed);
        idx = seed[6:0] | 7'h40;
        m_mode0 <= 1'b1;
        m_pick <= idx;
        poll(`OFF_SEQ_STATUS, 32'h1, 32'h0, "set 0");
        m_run <= 1'b1;
        poll(`OFF_SEQ_STATUS, 32'h3f86, {idx, 7'h2}, "start");
        m_run <= 1'b0;
        m_pick <= ~idx;
        poll(`OFF_SEQ_STATUS, 32'h6, 32'h6, "halt");
        m_run <= 1'b1;
        poll(`OFF_SEQ_STATUS, 32'h3f86, {idx, 7'h2}, "resume");
        m_run <= 1'b0;
        poll(`OFF_SEQ_STATUS, 32'h6, 32'h6, "halt again");
        m_clr <= 1'b1;
        poll(`OFF_SEQ_STATUS, 32'h6, 32'h0, "clear");
        m_clr <= 1'b0;
        m_run <= 1'b1;
        poll(`OFF_SEQ_STATUS, 32'h3f86, {~idx, 7'h2}, "restart");
        bus(1'b1, `OFF_SEQ_CMD, 32'h1);
        poll(`OFF_SEQ_STATUS, 32'h6, 32'h0, "table done");
        m_run <= 1'b0;
        bus(1'b0, `OFF_IRQ_STATUS, 32'h0);
        chk(rd, 32'h27, "table events");
        chk(irq, 1'b1, "irq raised");
        bus(1'b1, `OFF_IRQ_CLEAR, 32'h3f);
        bus(1'b0, `OFF_IRQ_STATUS, 32'h0);
        chk({rd[5:0], irq}, 7'h0, "irq cleared");
        // Manual set: mode change event, then masking
        m_mode0 <= 1'b0;
        poll(`OFF_SEQ_STATUS, 32'h1, 32'h1, "set 1");
        bus(1'b0, `OFF_IRQ_STATUS, 32'h0);
        chk({rd[5:0], irq}, 7'h41, "mode event");
        bus(1'b1, `OFF_IRQ_ENABLE, 32'h0);
        bus(1'b0, `OFF_IRQ_ENABLE, 32'h0);
        chk(rd, 32'h0, "enable readback");
        chk(irq, 1'b0, "irq masked");
        seed = lfsr(seed);
        m_clr <= 1'b1;
        m_pick <= {2'b00, seed[3:0], 1'b1};
        poll(`OFF_SEQ_STATUS, 32'h3c060, {seed[3:0], 14'h60}, "jog");
        m_clr <= 1'b0;
        m_pick <= 7'h0;
        poll(`OFF_SEQ_STATUS, 32'h60, 32'h0, "jog stop");
        // Homing: seek, pause, resume, finish
        m_run <= 1'b1;
        poll(`OFF_SEQ_STATUS, 32'h18, 32'h08, "seek");
        m_run <= 1'b0;
        poll(`OFF_SEQ_STATUS, 32'h18, 32'h18, "pause");
        m_run <= 1'b1;
        poll(`OFF_SEQ_STATUS, 32'h18, 32'h08, "seek again");
        bus(1'b1, `OFF_SEQ_CMD, 32'h2);
        poll(`OFF_SEQ_STATUS, 32'h18, 32'h0, "homing done");
        m_run <= 1'b0;
        bus(1'b0, `OFF_IRQ_STATUS, 32'h0);
        chk(rd, 32'h38, "homing events");
        chk(irq, 1'b0, "masked irq stays low");
        bus(1'b0, 8'h3c, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        stop_test();
    end
endmodule // indexer_sequence_io_tb
